// ### logic/ckl_cmd_seq.sv
// Command sequencer for key load from FIFO and two-phase card authentication
//
// Functional notes
// - Key load command 19h takes first twelve FIFO bytes, least significant first.
// - After all twelve bytes arrive, check format, copy valid key into key buffer.
// - Key load starts only on host request and ends itself after the copy.
// - Bad key format still loads an undefined key and raises key format error.
// - Phase one command 0Ch sends six FIFO bytes to the card, LSB first.
// - During both phases the card reply goes to the cipher, never the host.
// - Both phases run the send-then-receive state sequence of the transceive command.
// - Phase one starts only from a host request, never from an internal event.
// - Phase two command 14h uses no FIFO bytes; the device assembles its data.
// - Successful phase two sets the cipher active bit, encrypting later traffic.
// - Failed phase two clears the cipher active bit.
// - Host may clear the cipher active bit but never set it.
// - Any command error also sets the summary error flag beside the cause.
`timescale 1ns/100ps
`default_nettype none

module ckl_cmd_seq #(
    parameter int KEY_BYTES      = ckl_pkg::KEY_BYTES,
    parameter int AUTH_ONE_ARGS  = ckl_pkg::AUTH_ONE_ARGS,
    parameter int AUTH_TWO_BYTES = ckl_pkg::AUTH_TWO_TX_BYTES
) (
    // Clock and reset
    input  wire logic                     clock,
    input  wire logic                     rst_b,
    // Host command and control
    input  wire logic                     cmd_start,
    input  wire logic [7:0]               cmd_code,
    input  wire logic                     cipher_clr,
    input  wire logic                     fault_clr,
    // FIFO read side
    input  wire logic                     fifo_valid,
    input  wire logic [7:0]               fifo_data,
    output logic                          fifo_ready,
    // Send path towards the card
    output ckl_pkg::ckl_tx_t              tx,
    input  wire logic                     tx_ready,
    output logic [ckl_pkg::CNT_W-1:0]     tx_index,
    input  wire logic [7:0]               cipher_tx_data,
    // Receive path from the card
    input  wire logic                     rx_valid,
    input  wire logic [7:0]               rx_data,
    input  wire logic                     rx_end,
    input  wire logic                     auth_pass,
    output logic                          cipher_rx_valid,
    output logic [7:0]                    cipher_rx_data,
    // Results
    output logic [4*KEY_BYTES-1:0]        key_buf,
    output logic                          cipher_active_bit,
    output ckl_pkg::ckl_main_state_t      main_state_reg,
    output ckl_pkg::ckl_fault_t           fault_cause_reg,
    output logic                          cmd_done
);

    localparam logic [3:0] KEY_LAST   = 4'(KEY_BYTES - 1);
    localparam logic [3:0] AUTH1_LAST = 4'(AUTH_ONE_ARGS - 1);
    localparam logic [3:0] AUTH2_LAST = 4'(AUTH_TWO_BYTES - 1);

    logic                     rst_meta_r;
    logic                     rst_n;
    ckl_pkg::ckl_state_t      state_r;
    ckl_pkg::ckl_state_t      state_nxt;
    logic [7:0]               op_r;
    logic [3:0]               cnt_r;
    logic [8*KEY_BYTES-1:0]   key_raw_r;
    logic                     fifo_ready_r;
    logic                     fifo_ready_nxt;
    ckl_pkg::ckl_tx_t         tx_r;
    logic                     pass_r;
    logic                     cipher_rx_valid_r;
    logic [7:0]               cipher_rx_data_r;
    logic [4*KEY_BYTES-1:0]   key_buf_r;
    logic                     cipher_r;
    ckl_pkg::ckl_main_state_t main_r;
    ckl_pkg::ckl_fault_t      fault_r;
    logic                     done_r;
    logic                     take;
    logic                     is_auth1;
    logic                     is_auth2;
    logic                     key_ok;
    logic [4*KEY_BYTES-1:0]   key_val;

    assign take     = fifo_valid & fifo_ready_r;
    assign is_auth1 = (op_r == ckl_pkg::CMD_AUTH_ONE);
    assign is_auth2 = (op_r == ckl_pkg::CMD_AUTH_TWO);

    // Reset release through two stages; assertion stays asynchronous
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_meta_r <= 1'b0;
            rst_n      <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n      <= rst_meta_r;
        end
    end

    ckl_key_fmt #(
        .KEY_BYTES (KEY_BYTES)
    ) u_key_fmt (
        .key_raw (key_raw_r),
        .key_ok  (key_ok),
        .key_val (key_val)
    );

    // Only a host start leaves idle; starts while busy are ignored
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ckl_pkg::ST_IDLE:
            begin
                if (cmd_start)
                begin
                    if (cmd_code == ckl_pkg::CMD_KEY_FROM_FIFO)
                        state_nxt = ckl_pkg::ST_KEY_COLLECT;
                    else if (cmd_code == ckl_pkg::CMD_AUTH_ONE ||
                             cmd_code == ckl_pkg::CMD_AUTH_TWO)
                        state_nxt = ckl_pkg::ST_TX_FETCH;
                end
            end
            ckl_pkg::ST_KEY_COLLECT:
            begin
                if (take && cnt_r == KEY_LAST)
                    state_nxt = ckl_pkg::ST_KEY_STORE;
            end
            ckl_pkg::ST_KEY_STORE:
                state_nxt = ckl_pkg::ST_IDLE;
            ckl_pkg::ST_TX_FETCH:
            begin
                if (is_auth2 || take)
                    state_nxt = ckl_pkg::ST_TX_SEND;
            end
            ckl_pkg::ST_TX_SEND:
            begin
                if (tx_ready)
                    state_nxt = tx_r.last ? ckl_pkg::ST_RX_WAIT : ckl_pkg::ST_TX_FETCH;
            end
            ckl_pkg::ST_RX_WAIT:
            begin
                if (rx_end)
                    state_nxt = ckl_pkg::ST_FINISH;
            end
            ckl_pkg::ST_FINISH:
                state_nxt = ckl_pkg::ST_IDLE;
            default:
                state_nxt = ckl_pkg::ST_IDLE;
        endcase
    end

    // Phase two never reads the FIFO; its bytes come from the cipher
    assign fifo_ready_nxt = (state_nxt == ckl_pkg::ST_KEY_COLLECT) ||
        (state_nxt == ckl_pkg::ST_TX_FETCH &&
         (state_r == ckl_pkg::ST_IDLE ? cmd_code == ckl_pkg::CMD_AUTH_ONE : is_auth1));

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r      <= ckl_pkg::ST_IDLE;
            fifo_ready_r <= 1'b0;
            op_r         <= ckl_pkg::BYTE_RST;
            done_r       <= 1'b0;
        end
        else
        begin
            state_r      <= state_nxt;
            fifo_ready_r <= fifo_ready_nxt;
            done_r       <= (state_r == ckl_pkg::ST_KEY_STORE) || (state_r == ckl_pkg::ST_FINISH);
            if (state_r == ckl_pkg::ST_IDLE && cmd_start)
                op_r <= cmd_code;
        end
    end

    // Byte counter: key bytes taken, or bytes handed to the send path
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            cnt_r <= ckl_pkg::CNT_RST;
        else if (state_r == ckl_pkg::ST_IDLE)
            cnt_r <= ckl_pkg::CNT_RST;
        else if ((state_r == ckl_pkg::ST_KEY_COLLECT && take) ||
                 (state_r == ckl_pkg::ST_TX_SEND && tx_ready))
            cnt_r <= cnt_r + ckl_pkg::CNT_ONE;
    end

    // Key bytes land least significant first
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            key_raw_r <= '0;
        else if (state_r == ckl_pkg::ST_KEY_COLLECT && take)
            key_raw_r[8*cnt_r +: 8] <= fifo_data;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            key_buf_r <= '0;
        else if (state_r == ckl_pkg::ST_KEY_STORE)
            key_buf_r <= key_val;
    end

    // Send register holds one byte until the send path accepts it
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            tx_r <= '0;
        else if (state_r == ckl_pkg::ST_TX_FETCH && is_auth1 && take)
        begin
            tx_r.valid <= 1'b1;
            tx_r.last  <= (cnt_r == AUTH1_LAST);
            tx_r.data  <= fifo_data;
        end
        else if (state_r == ckl_pkg::ST_TX_FETCH && is_auth2)
        begin
            tx_r.valid <= 1'b1;
            tx_r.last  <= (cnt_r == AUTH2_LAST);
            tx_r.data  <= cipher_tx_data;
        end
        else if (state_r == ckl_pkg::ST_TX_SEND && tx_ready)
        begin
            tx_r.valid <= 1'b0;
            tx_r.last  <= 1'b0;
        end
    end

    // Card reply is steered to the cipher only; the host never sees it
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cipher_rx_valid_r <= 1'b0;
            cipher_rx_data_r  <= ckl_pkg::BYTE_RST;
            pass_r            <= 1'b0;
        end
        else
        begin
            cipher_rx_valid_r <= (state_r == ckl_pkg::ST_RX_WAIT) && rx_valid;
            if ((state_r == ckl_pkg::ST_RX_WAIT) && rx_valid)
                cipher_rx_data_r <= rx_data;
            if ((state_r == ckl_pkg::ST_RX_WAIT) && rx_end)
                pass_r <= auth_pass;
        end
    end

    // Set by phase two wins over a host clear in the same cycle
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            cipher_r <= ckl_pkg::CIPHER_RST;
        else if (state_r == ckl_pkg::ST_FINISH && is_auth2 && pass_r)
            cipher_r <= 1'b1;
        else if (state_r == ckl_pkg::ST_FINISH && is_auth2)
            cipher_r <= 1'b0;
        else if (cipher_clr)
            cipher_r <= 1'b0;
    end

    // Error flags are sticky; a new error beats a host clear
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fault_r <= '0;
            main_r  <= '0;
        end
        else
        begin
            main_r.busy <= (state_nxt != ckl_pkg::ST_IDLE);
            if (state_r == ckl_pkg::ST_KEY_STORE && !key_ok)
            begin
                fault_r.key_format_error <= 1'b1;
                main_r.err               <= 1'b1;
            end
            else if (fault_clr)
            begin
                fault_r.key_format_error <= 1'b0;
                main_r.err               <= 1'b0;
            end
        end
    end

    assign fifo_ready        = fifo_ready_r;
    assign tx                = tx_r;
    assign tx_index          = cnt_r;
    assign cipher_rx_valid   = cipher_rx_valid_r;
    assign cipher_rx_data    = cipher_rx_data_r;
    assign key_buf           = key_buf_r;
    assign cipher_active_bit = cipher_r;
    assign main_state_reg    = main_r;
    assign fault_cause_reg   = fault_r;
    assign cmd_done          = done_r;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_key_lsb_first;
        state_r == ckl_pkg::ST_KEY_COLLECT && take && cnt_r == ckl_pkg::CNT_RST
            |=> key_raw_r[7:0] == $past(fifo_data);
    endproperty
    a_key_lsb_first: assert property (p_key_lsb_first) else $error("first key byte misplaced");

    property p_key_copy;
        state_r == ckl_pkg::ST_KEY_STORE |=> key_buf_r == $past(key_val);
    endproperty
    a_key_copy: assert property (p_key_copy) else $error("key buffer not loaded");

    property p_key_self_stop;
        state_r == ckl_pkg::ST_KEY_STORE |=> state_r == ckl_pkg::ST_IDLE && done_r;
    endproperty
    a_key_self_stop: assert property (p_key_self_stop) else $error("key load did not end");

    property p_key_err;
        state_r == ckl_pkg::ST_KEY_STORE && !key_ok
            |=> fault_r.key_format_error && main_r.err;
    endproperty
    a_key_err: assert property (p_key_err) else $error("format error not flagged");

    property p_auth1_six;
        tx_r.valid && tx_r.last && is_auth1 |-> cnt_r == AUTH1_LAST;
    endproperty
    a_auth1_six: assert property (p_auth1_six) else $error("phase one byte count wrong");

    property p_rx_to_cipher;
        state_r == ckl_pkg::ST_RX_WAIT && rx_valid
            |=> cipher_rx_valid_r && cipher_rx_data_r == $past(rx_data);
    endproperty
    a_rx_to_cipher: assert property (p_rx_to_cipher) else $error("reply not consumed");

    property p_send_then_recv;
        state_r == ckl_pkg::ST_TX_SEND && tx_ready && tx_r.last
            |=> state_r == ckl_pkg::ST_RX_WAIT ##1 !tx_r.valid;
    endproperty
    a_send_then_recv: assert property (p_send_then_recv) else $error("sequence broken");

    property p_host_start;
        $rose(main_r.busy) |-> $past(cmd_start);
    endproperty
    a_host_start: assert property (p_host_start) else $error("start without host");

    property p_auth2_no_fifo;
        state_r != ckl_pkg::ST_IDLE && is_auth2 |-> !fifo_ready_r;
    endproperty
    a_auth2_no_fifo: assert property (p_auth2_no_fifo) else $error("phase two read FIFO");

    property p_cipher_set;
        state_r == ckl_pkg::ST_FINISH && is_auth2 && pass_r |=> cipher_r;
    endproperty
    a_cipher_set: assert property (p_cipher_set) else $error("cipher not enabled");

    property p_cipher_fail;
        state_r == ckl_pkg::ST_FINISH && is_auth2 && !pass_r |=> !cipher_r;
    endproperty
    a_cipher_fail: assert property (p_cipher_fail) else $error("cipher not cleared");

    property p_cipher_only_auth;
        $rose(cipher_r) |-> $past(state_r == ckl_pkg::ST_FINISH && is_auth2 && pass_r);
    endproperty
    a_cipher_only_auth: assert property (p_cipher_only_auth) else $error("cipher set wrongly");

    property p_key_wait;
        state_r == ckl_pkg::ST_KEY_COLLECT && !fifo_valid
            |=> state_r == ckl_pkg::ST_KEY_COLLECT && fifo_ready_r;
    endproperty
    a_key_wait: assert property (p_key_wait) else $error("key load gave up");

    c_key_load: cover property (state_r == ckl_pkg::ST_KEY_STORE && key_ok);
    c_key_bad: cover property (state_r == ckl_pkg::ST_KEY_STORE && !key_ok);
    c_auth_ok: cover property ($rose(cipher_r));
    c_auth_fail: cover property (state_r == ckl_pkg::ST_FINISH && is_auth2 && !pass_r);

endmodule

`default_nettype wire

// ### logic/ckl_pkg.sv
// Shared constants and types for the card key load and authentication sequencer
package ckl_pkg;

    localparam int          CNT_W            = 4;
    localparam logic [7:0]  CMD_KEY_FROM_FIFO = 8'h19;
    localparam logic [7:0]  CMD_AUTH_ONE      = 8'h0C;
    localparam logic [7:0]  CMD_AUTH_TWO      = 8'h14;
    localparam int          KEY_BYTES         = 12;
    localparam int          AUTH_ONE_ARGS     = 6;
    localparam int          AUTH_TWO_TX_BYTES = 8;
    localparam logic [3:0]  CNT_RST           = 4'h0;
    localparam logic [3:0]  CNT_ONE           = 4'h1;
    localparam logic [7:0]  BYTE_RST          = 8'h00;
    localparam logic        CIPHER_RST        = 1'b0;

    typedef enum {
        ST_IDLE,
        ST_KEY_COLLECT,
        ST_KEY_STORE,
        ST_TX_FETCH,
        ST_TX_SEND,
        ST_RX_WAIT,
        ST_FINISH
    } ckl_state_t;

    typedef struct packed {
        logic       valid;
        logic       last;
        logic [7:0] data;
    } ckl_tx_t;

    typedef struct packed {
        logic err;
        logic busy;
    } ckl_main_state_t;

    typedef struct packed {
        logic key_format_error;
    } ckl_fault_t;

endpackage

// ### logic/ckl_key_fmt.sv
// Key format check and nibble extraction for the twelve raw key bytes
`timescale 1ns/100ps
`default_nettype none

module ckl_key_fmt #(
    parameter int KEY_BYTES = ckl_pkg::KEY_BYTES
) (
    // Raw key, byte 0 in the low bits
    input  wire logic [8*KEY_BYTES-1:0] key_raw,
    // Check result and packed key
    output logic                        key_ok,
    output logic [4*KEY_BYTES-1:0]      key_val
);

    // Each byte carries one key nibble in the low half and its complement above
    function automatic logic byte_ok(input logic [7:0] b);
        byte_ok = (b[7:4] == ~b[3:0]);
    endfunction

    always_comb
    begin
        key_ok  = 1'b1;
        key_val = '0;
        for (int i = 0; i < KEY_BYTES; i++)
        begin
            key_ok           = key_ok & byte_ok(key_raw[8*i +: 8]);
            // On a bad format the low nibbles still load: the buffer value is undefined
            key_val[4*i +: 4] = key_raw[8*i +: 4];
        end
    end

endmodule

`default_nettype wire

// ### sim/ckl_card_model.sv
// Behavioural contactless card on the far side of the send and receive path
`timescale 1ns/100ps
`default_nettype none

module ckl_card_model #(
    parameter int         REPLY_N    = 4,
    parameter logic [7:0] REPLY_BASE = 8'hA0
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst_b,
    // Send path from the reader
    input  wire ckl_pkg::ckl_tx_t tx,
    output logic                  tx_ready = 1'b0,
    // Reply towards the reader
    output logic                  rx_valid = 1'b0,
    output logic [7:0]            rx_data = 8'h00,
    output logic                  rx_end = 1'b0,
    output logic                  auth_pass = 1'b0,
    // Behaviour controls
    input  wire logic             slow,
    input  wire logic             verdict
);
    logic [7:0] got[$];
    int         ends[$];
    int         lasts = 0;
    int         served = 0;
    int         wait_cnt = 0;
    int         reply_cnt = -1;

    always @(posedge clock)
    begin
        if (tx.valid === 1'b1 && tx_ready === 1'b1)
        begin
            got.push_back(tx.data);
            if (tx.last === 1'b1)
            begin
                ends.push_back(got.size());
                lasts++;
            end
        end
    end

    // Lines are never left at their last value between reply bytes
    always @(negedge clock)
    begin
        rx_valid <= rst_b && reply_cnt >= 0 && reply_cnt < REPLY_N;
        rx_end <= rst_b && reply_cnt == REPLY_N;
        rx_data <= (rst_b && reply_cnt >= 0 && reply_cnt < REPLY_N) ?
            REPLY_BASE + 8'(reply_cnt) : ~rx_data;
        auth_pass <= (rst_b && reply_cnt == REPLY_N) ? verdict : ~verdict;
        if (!rst_b)
        begin
            tx_ready <= 1'b0;
            reply_cnt = -1;
            served = lasts;
        end
        else
        begin
            if (tx_ready)
                tx_ready <= 1'b0;
            else if (tx.valid === 1'b1)
            begin
                if (wait_cnt >= (slow ? 3 : 0))
                begin
                    tx_ready <= 1'b1;
                    wait_cnt = 0;
                end
                else
                    wait_cnt++;
            end
            if (reply_cnt < 0 && served != lasts)
            begin
                served = lasts;
                reply_cnt = 0;
            end
            else if (reply_cnt >= 0 && reply_cnt < REPLY_N)
                reply_cnt++;
            else if (reply_cnt == REPLY_N)
                reply_cnt = -1;
        end
    end
endmodule

`default_nettype wire

// ### sim/tb_top.sv
// Self-checking bench for the key load and card authentication sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end

module tb_top;
    localparam int         REPLY_N    = 4;
    localparam logic [7:0] REPLY_BASE = 8'hA0;

    logic                        clock = 1'b0;
    logic                        rst_b = 1'b0;
    logic                        cmd_start = 1'b0;
    logic [7:0]                  cmd_code = 8'h00;
    logic                        cipher_clr = 1'b0;
    logic                        fault_clr = 1'b0;
    logic                        fifo_valid = 1'b0;
    logic [7:0]                  fifo_data = 8'h00;
    logic                        fifo_ready;
    ckl_pkg::ckl_tx_t            tx;
    logic                        tx_ready;
    logic [ckl_pkg::CNT_W-1:0]   tx_index;
    logic [7:0]                  cipher_tx_data = 8'h00;
    logic                        rx_valid;
    logic [7:0]                  rx_data;
    logic                        rx_end;
    logic                        auth_pass;
    logic                        cipher_rx_valid;
    logic [7:0]                  cipher_rx_data;
    logic [47:0]                 key_buf;
    logic                        cipher_active_bit;
    ckl_pkg::ckl_main_state_t    main_state_reg;
    ckl_pkg::ckl_fault_t         fault_cause_reg;
    logic                        cmd_done;
    logic                        slow = 1'b0;
    logic                        verdict = 1'b0;
    logic                        taken = 1'b0;
    logic [7:0]                  fq[$];
    logic [7:0]                  rxq[$];
    int                          checked = 0;
    int                          mismatches = 0;

    ckl_cmd_seq ckl_cmd_seq_i (.clock(clock), .rst_b(rst_b), .cmd_start(cmd_start),
        .cmd_code(cmd_code), .cipher_clr(cipher_clr), .fault_clr(fault_clr),
        .fifo_valid(fifo_valid), .fifo_data(fifo_data), .fifo_ready(fifo_ready), .tx(tx),
        .tx_ready(tx_ready), .tx_index(tx_index), .cipher_tx_data(cipher_tx_data),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end), .auth_pass(auth_pass),
        .cipher_rx_valid(cipher_rx_valid), .cipher_rx_data(cipher_rx_data), .key_buf(key_buf),
        .cipher_active_bit(cipher_active_bit), .main_state_reg(main_state_reg),
        .fault_cause_reg(fault_cause_reg), .cmd_done(cmd_done));

    ckl_card_model #(.REPLY_N(REPLY_N), .REPLY_BASE(REPLY_BASE)) ckl_card_model_i (
        .clock(clock), .rst_b(rst_b), .tx(tx), .tx_ready(tx_ready), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_end(rx_end), .auth_pass(auth_pass), .slow(slow),
        .verdict(verdict));

    function automatic logic [7:0] ciph_byte(input logic [3:0] i);
        return 8'h3C ^ {i, i};
    endfunction

    initial
    begin
        forever #50 clock = ~clock;
    end

    // Show-ahead FIFO: a presented byte holds until popped, arrivals have random gaps
    always @(posedge clock) taken <= fifo_valid & fifo_ready;
    always @(negedge clock)
    begin
        if (taken && fq.size() > 0)
            void'(fq.pop_front());
        if (fq.size() > 0 && ((fifo_valid && !taken) || $urandom_range(1, 0) == 1))
        begin
            fifo_valid <= 1'b1;
            fifo_data <= fq[0];
        end
        else
        begin
            fifo_valid <= 1'b0;
            fifo_data <= ~fifo_data;
        end
        cipher_tx_data <= ciph_byte(tx_index);
    end
    always @(posedge clock) if (cipher_rx_valid === 1'b1) rxq.push_back(cipher_rx_data);

    task automatic final_report;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic start(input logic [7:0] code);
        cmd_code = code;
        cmd_start = 1'b1;
        @(negedge clock);
        cmd_start = 1'b0;
        @(negedge clock);
    endtask

    task automatic pulse(ref logic sig);
        sig = 1'b1;
        @(negedge clock);
        sig = 1'b0;
        repeat (2) @(negedge clock);
    endtask

    task automatic wait_done;
        int n;
        n = 0;
        while (cmd_done !== 1'b1 && n < 500)
        begin
            @(negedge clock);
            #1;
            n++;
        end
        `CHK(cmd_done, 1'b1)
        `CHK(main_state_reg.busy, 1'b0)
    endtask

    task automatic check_reply;
        `CHK(rxq.size(), REPLY_N)
        for (int k = 0; k < REPLY_N; k++)
            `CHK(rxq[k], REPLY_BASE + 8'(k))
        rxq.delete();
    endtask

    initial
    begin
        #(100 * 30000);
        mismatches++;
        final_report;
    end

    initial
    begin
        logic [47:0] key_exp;
        logic [3:0]  nib;
        logic [7:0]  args[6];
        logic        bad;
        logic        prev;
        void'($urandom(32'hD7F0323B));
        repeat (5) @(negedge clock);
        rst_b = 1'b1;
        repeat (4) @(negedge clock);
        `CHK({main_state_reg, fault_cause_reg, cipher_active_bit, key_buf}, 52'h0)
        for (int t = 0; t < 3; t++)
        begin
            bad = (t == 1);
            start(ckl_pkg::CMD_KEY_FROM_FIFO);
            repeat (4) @(negedge clock);
            `CHK(main_state_reg.busy, 1'b1)
            `CHK(fifo_ready, 1'b1)
            start(ckl_pkg::CMD_AUTH_ONE);
            for (int i = 0; i < 12; i++)
            begin
                nib = 4'($urandom_range(15, 0));
                key_exp[4*i +: 4] = nib;
                fq.push_back({(bad && i == 11) ? nib : ~nib, nib});
            end
            wait_done;
            `CHK(fq.size(), 0)
            if (!bad)
                `CHK(key_buf, key_exp)
            `CHK(fault_cause_reg.key_format_error, bad)
            `CHK(main_state_reg.err, bad)
            repeat (3) @(negedge clock);
            `CHK(main_state_reg.busy, 1'b0)
            pulse(fault_clr);
            `CHK({main_state_reg.err, fault_cause_reg}, 2'h0)
            $display("test key_load %0d done", t);
        end
        start(8'h55);
        `CHK(main_state_reg.busy, 1'b0)
        $display("test unknown_code done");
        for (int t = 0; t < 4; t++)
        begin
            slow = (t % 2 == 1);
            verdict = (t != 1);
            prev = cipher_active_bit;
            ckl_card_model_i.got.delete();
            ckl_card_model_i.ends.delete();
            for (int i = 0; i < 6; i++)
            begin
                args[i] = 8'($urandom());
                fq.push_back(args[i]);
            end
            if (t == 0)
            begin
                repeat (10) @(negedge clock);
                `CHK(main_state_reg.busy, 1'b0)
                `CHK(fq.size(), 6)
            end
            start(ckl_pkg::CMD_AUTH_ONE);
            wait_done;
            `CHK(ckl_card_model_i.ends[0], 6)
            for (int i = 0; i < 6; i++)
                `CHK(ckl_card_model_i.got[i], args[i])
            check_reply;
            `CHK(cipher_active_bit, prev)
            fq.push_back(8'h5A);
            fq.push_back(8'hA5);
            start(ckl_pkg::CMD_AUTH_TWO);
            wait_done;
            `CHK(ckl_card_model_i.ends[1], 6 + ckl_pkg::AUTH_TWO_TX_BYTES)
            for (int i = 0; i < ckl_pkg::AUTH_TWO_TX_BYTES; i++)
                `CHK(ckl_card_model_i.got[6 + i], ciph_byte(4'(i)))
            `CHK(fq.size(), 2)
            fq.delete();
            check_reply;
            `CHK(cipher_active_bit, verdict)
            if (t == 2)
            begin
                pulse(cipher_clr);
                `CHK(cipher_active_bit, 1'b0)
            end
            $display("test auth %0d done", t);
        end
        final_report;
    end
endmodule

`default_nettype wire
